// *** hw/ecs_pkg.sv ***
// Constants and register map of the event channel status block
//
// Operation
// - One busy bit per channel, bits 27:24,15:8
// - Busy set while any connected user pending
// - Busy cleared when channel is idle
// - One users-ready bit per channel, bits 19:16,7:0
// - Ready only when all connected users ready
// - Users 0x07..0x16 accept async, sync, resync paths
package ecs_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_CHANNEL_STATE = 12'h00C;
    localparam logic [11:0] OFS_INT_MASK = 12'h010;
    localparam logic [11:0] OFS_INT_FLAG = 12'h014;
    localparam logic [11:0] OFS_USER_BASE = 12'h080;

    // ------------------------------------------------------------
    // Status word layout and reset value
    // ------------------------------------------------------------
    localparam int BUSY_LO_POS = 8;
    localparam int BUSY_HI_POS = 24;
    localparam int READY_LO_POS = 0;
    localparam int READY_HI_POS = 16;
    localparam int LO_CHANNELS = 8;
    localparam logic [31:0] CHANNEL_STATE_RESET = 32'h000F00FF;

    // ------------------------------------------------------------
    // User table: index range and configuration word layout
    // ------------------------------------------------------------
    localparam logic [7:0] USER_FIRST = 8'h07;
    localparam logic [7:0] USER_LAST = 8'h16;
    localparam int SEL_W = 5;
    localparam int PATH_POS = 8;
    localparam logic [31:0] USER_CFG_MASK = 32'h0000031F;
    localparam logic [31:0] USER_CFG_RESET = 32'h00000000;

    typedef enum logic [1:0] {
        ECS_PATH_SYNC = 2'b00,
        ECS_PATH_RESYNC = 2'b01,
        ECS_PATH_ASYNC = 2'b10
    } ecs_path_e;

endpackage

// *** hw/ecs_event_channel_status.sv ***
// Event channel status, user path routing and APB register slave
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
module ecs_event_channel_status
    import ecs_pkg::*;
#(
    parameter int NUM_CH = 12,
    parameter int NUM_USERS = 16
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_CH-1:0] chanEvent,
    input wire logic [NUM_USERS-1:0] userReady,
    input wire logic [NUM_USERS-1:0] userAck,
    output logic [NUM_USERS-1:0] userEvent,
    output logic irq
);

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------

    // Byte address of the configuration word of local user u
    function automatic logic [11:0] userOffset(input int u);
        logic [11:0] idx;
        idx = 12'(int'(USER_FIRST) + u);
        return OFS_USER_BASE + {idx[9:0], 2'b00};
    endfunction

    // Channel hit for a select field: 0 is unconnected, n is channel n-1
    function automatic logic selHits(input logic [SEL_W-1:0] sel,
                                     input int ch);
        return sel == SEL_W'(ch + 1);
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [31:0] userCfg [NUM_USERS];
    logic [NUM_USERS-1:0] pending;
    logic [NUM_USERS-1:0] userHit;
    logic [NUM_USERS-1:0] syncStage;
    logic [NUM_USERS-1:0] resyncStage1;
    logic [NUM_USERS-1:0] resyncStage2;
    logic [NUM_USERS-1:0] userCfgSel;
    logic [NUM_CH-1:0] chanBusy;
    logic [NUM_CH-1:0] chanReady;
    logic [NUM_CH-1:0] busyPrev;
    logic [NUM_CH-1:0] intFlag;
    logic [NUM_CH-1:0] intMask;
    logic [31:0] stateWord;
    logic [31:0] userReadData;
    logic [31:0] next_prdata;
    logic userMapped;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------

    // Zero wait states: every access completes in its first cycle
    wire setupPhase = psel && !penable;
    wire accessPhase = psel && penable;
    wire writeStrobe = accessPhase && pwrite;
    wire hitState = paddr == OFS_CHANNEL_STATE;
    wire hitMask = paddr == OFS_INT_MASK;
    wire hitFlag = paddr == OFS_INT_FLAG;
    wire mapped = hitState || hitMask || hitFlag || userMapped;
    wire writeMask = writeStrobe && hitMask;
    wire writeFlag = writeStrobe && hitFlag;
    assign pready = 1'b1;
    // Unmapped addresses and writes to the read-only status word fail
    assign pslverr = accessPhase && (!mapped || (pwrite && hitState));

    // ------------------------------------------------------------
    // User path table and per-user event delivery
    // ------------------------------------------------------------
    generate
        for (genvar u = 0; u < NUM_USERS; u++) begin : gUser
            wire [SEL_W-1:0] sel = userCfg[u][SEL_W-1:0];
            wire [1:0] path = userCfg[u][PATH_POS+1:PATH_POS];
            logic hit;

            assign userCfgSel[u] = paddr == userOffset(u);

            // Event on the channel this user is attached to
            always_comb begin
                hit = 1'b0;
                for (int ch = 0; ch < NUM_CH; ch++) begin
                    if (selHits(sel, ch) && chanEvent[ch]) begin
                        hit = 1'b1;
                    end
                end
            end
            assign userHit[u] = hit;

            // Path choice: async passes straight, sync one flop, resync two
            assign userEvent[u] = (path == ECS_PATH_ASYNC) ? userHit[u] :
                (path == ECS_PATH_RESYNC) ? resyncStage2[u] : syncStage[u];

            // Path stages, configuration and outstanding-event tracking
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    userCfg[u] <= USER_CFG_RESET;
                    syncStage[u] <= 1'b0;
                    resyncStage1[u] <= 1'b0;
                    resyncStage2[u] <= 1'b0;
                    pending[u] <= 1'b0;
                end else begin
                    syncStage[u] <= userHit[u];
                    resyncStage1[u] <= userHit[u];
                    resyncStage2[u] <= resyncStage1[u];
                    if (writeStrobe && userCfgSel[u]) begin
                        userCfg[u] <= pwdata & USER_CFG_MASK;
                    end
                    // A new event wins over an acknowledge in the same cycle
                    if (userHit[u]) begin
                        pending[u] <= 1'b1;
                    end else if (userAck[u]) begin
                        pending[u] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    assign userMapped = |userCfgSel;

    // Read data of the addressed user configuration word
    always_comb begin
        userReadData = 32'h00000000;
        for (int u = 0; u < NUM_USERS; u++) begin
            if (userCfgSel[u]) begin
                userReadData = userCfg[u];
            end
        end
    end

    // ------------------------------------------------------------
    // Channel busy and users-ready, live from the user handshake
    // ------------------------------------------------------------

    // A channel with no users is idle and reads as ready
    always_comb begin
        for (int ch = 0; ch < NUM_CH; ch++) begin
            chanBusy[ch] = 1'b0;
            chanReady[ch] = 1'b1;
            for (int u = 0; u < NUM_USERS; u++) begin
                if (selHits(userCfg[u][SEL_W-1:0], ch)) begin
                    chanBusy[ch] = chanBusy[ch] | pending[u];
                    chanReady[ch] = chanReady[ch] & userReady[u];
                end
            end
        end
    end

    // Pack channels into the status word, upper channels in the high bytes
    always_comb begin
        stateWord = 32'h00000000;
        for (int ch = 0; ch < NUM_CH; ch++) begin
            if (ch < LO_CHANNELS) begin
                stateWord[BUSY_LO_POS+ch] = chanBusy[ch];
                stateWord[READY_LO_POS+ch] = chanReady[ch];
            end else begin
                stateWord[BUSY_HI_POS+ch-LO_CHANNELS] = chanBusy[ch];
                stateWord[READY_HI_POS+ch-LO_CHANNELS] = chanReady[ch];
            end
        end
    end

    // ------------------------------------------------------------
    // Channel-done interrupt: sticky flags, mask, one level output
    // ------------------------------------------------------------
    wire [NUM_CH-1:0] chanDone = busyPrev & ~chanBusy;
    wire [NUM_CH-1:0] flagClear = writeFlag ? pwdata[NUM_CH-1:0] : '0;
    assign irq = |(intFlag & intMask);

    // Flag set by a finished channel wins over a clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            busyPrev <= '0;
            intFlag <= '0;
            intMask <= '0;
        end else begin
            busyPrev <= chanBusy;
            intFlag <= (intFlag & ~flagClear) | chanDone;
            if (writeMask) begin
                intMask <= pwdata[NUM_CH-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Read data, captured in the setup cycle
    // ------------------------------------------------------------
    always_comb begin
        next_prdata = 32'h00000000;
        if (hitState) begin
            next_prdata = stateWord;
        end else if (hitMask) begin
            next_prdata[NUM_CH-1:0] = intMask;
        end else if (hitFlag) begin
            next_prdata[NUM_CH-1:0] = intFlag;
        end else if (userMapped) begin
            next_prdata = userReadData;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prdata <= CHANNEL_STATE_RESET;
        end else if (setupPhase && !pwrite) begin
            prdata <= next_prdata;
        end
    end

endmodule

// *** testbench/ecs_status_asserts.sv ***
// Port checker for the event channel status block
`timescale 1ns/1ps
module ecs_status_asserts #(
    parameter int NUM_CH = 12,
    parameter int NUM_USERS = 16
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NUM_CH-1:0] chanEvent,
    input wire logic [NUM_USERS-1:0] userReady,
    input wire logic [NUM_USERS-1:0] userAck,
    input wire logic [NUM_USERS-1:0] userEvent,
    input wire logic irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Read setup of the status word, and any access cycle
    sequence s_rd;
        psel && !penable && !pwrite && paddr == 12'h00C;
    endsequence
    sequence s_acc;
        psel && penable;
    endsequence
    property p_ro; s_acc ##0 pwrite && paddr == 12'h00C |-> pslverr;
    endproperty
    a_ro: assert property (p_ro) else $error("status write taken");
    property p_lay; s_rd |=> prdata[31:28] == 0 && prdata[23:20] == 0;
    endproperty
    a_lay: assert property (p_lay) else $error("unused bits set");
    property p_rdy; s_rd ##0 (&userReady && $past(&userReady))
        |=> prdata[7:0] == 8'hFF && prdata[19:16] == 4'hF; endproperty
    a_rdy: assert property (p_rdy) else $error("ready bit low");
    property p_cause; |userEvent |-> |chanEvent || $past(|chanEvent)
        || $past(|chanEvent, 2); endproperty
    a_cause: assert property (p_cause) else $error("stray user event");
    property p_hold; !(psel && !penable && !pwrite) |=> $stable(prdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_err; !(psel && penable) |-> !pslverr; endproperty
    a_err: assert property (p_err) else $error("error outside access");
    property p_fall; $fell(irq) |-> $past(psel && penable && pwrite);
    endproperty
    a_fall: assert property (p_fall) else $error("irq dropped alone");
    property p_rise; $rose(irq) |-> $past(|userAck, 2)
        || $past(psel && penable && pwrite); endproperty
    a_rise: assert property (p_rise) else $error("irq raised alone");
endmodule
bind ecs_event_channel_status ecs_status_asserts #(.NUM_CH(NUM_CH),
    .NUM_USERS(NUM_USERS)) u_chk (.ref_clk, .rst, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .chanEvent, .userReady,
    .userAck, .userEvent, .irq);

// *** testbench/ecs_user_model.sv ***
// Behavioural event users: hold events, ack one cycle later unless stalled
`timescale 1ns/1ps
module ecs_user_model #(
    parameter int N = 16
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic stall,
    input wire logic [N-1:0] userEvent,
    output logic [N-1:0] userReady,
    output logic [N-1:0] userAck
);
    logic [N-1:0] pend;
    // Busy or stalled users are not ready
    assign userReady = stall ? '0 : ~pend;
    // Latch events, ack them when not stalled
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pend <= '0;
            userAck <= '0;
        end else begin
            userAck <= stall ? '0 : pend;
            pend <= stall ? (pend | userEvent) : userEvent;
        end
    end
endmodule

// *** testbench/ecs_event_channel_status_tb.sv ***
// Self-checking bench for the event channel status block
`timescale 1ns/1ps
module ecs_event_channel_status_tb import ecs_pkg::*;;
    logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic stall = 1, pready, pslverr, irq, rerr;
    logic [11:0] paddr = 0, chanEvent = 0;
    logic [31:0] pwdata = 0, prdata, rdat, cfg;
    logic [15:0] userReady, userAck, userEvent;
    int n_mismatch = 0, checks_done = 0, cyc = 0;
    ecs_event_channel_status u_dut (.ref_clk, .rst, .paddr, .psel, .penable,
        .pwrite, .pwdata, .prdata, .pready, .pslverr, .chanEvent, .userReady,
        .userAck, .userEvent, .irq);
    ecs_user_model u_usr (.ref_clk, .rst, .stall, .userEvent, .userReady,
        .userAck);
    initial forever #12.5 ref_clk = ~ref_clk;
    // Cycle ceiling against hangs
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end
    task automatic chk(input string nm, input logic [31:0] s, e);
        checks_done++;
        if (s !== e) begin
            n_mismatch++;
            $display("unexpected %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // One APB transfer, held until pready is seen high
    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e,
                      input logic r);
        apb(a, 1'b0, 32'h0);
        chk("rdata", rdat, e);
        chk("slverr", {31'h0, rerr}, {31'h0, r});
    endtask
    task automatic pulse(input int ch);
        @(posedge ref_clk);
        chanEvent <= 12'h001 << ch;
        @(posedge ref_clk);
        chanEvent <= 12'h000;
    endtask
    // Fire channels 1..3 and follow each path stage at the falling edge
    task automatic path_chk(input logic [15:0] e0, e1, e2);
        @(posedge ref_clk);
        chanEvent <= 12'h00E;
        @(negedge ref_clk);
        chk("userEvent async", {16'h0, userEvent}, {16'h0, e0});
        @(posedge ref_clk);
        chanEvent <= 12'h000;
        @(negedge ref_clk);
        chk("userEvent sync", {16'h0, userEvent}, {16'h0, e1});
        @(negedge ref_clk);
        chk("userEvent resync", {16'h0, userEvent}, {16'h0, e2});
    endtask
    task automatic irq_is(input logic v);
        @(negedge ref_clk);
        chk("irq", {31'h0, irq}, {31'h0, v});
    endtask
    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 0;
        rd(OFS_CHANNEL_STATE, CHANNEL_STATE_RESET, 1'b0);
        apb(OFS_CHANNEL_STATE, 1'b1, 32'hFFFFFFFF);
        chk("werr", {31'h0, rerr}, 32'h1);
        rd(OFS_CHANNEL_STATE, CHANNEL_STATE_RESET, 1'b0);
        rd(12'h000, 32'h0, 1'b1);
        // User u on channel u mod 12, paths cycle sync, resync, async
        for (int u = 0; u < 16; u++) begin
            cfg = {22'h0, 2'(u % 3), 3'h0, 5'(u % 12 + 1)};
            apb(OFS_USER_BASE + 12'(4 * (7 + u)), 1'b1, cfg);
            rd(OFS_USER_BASE + 12'(4 * (7 + u)), cfg, 1'b0);
        end
        rd(OFS_CHANNEL_STATE, 32'h0, 1'b0);
        pulse(3);
        pulse(9);
        rd(OFS_CHANNEL_STATE, 32'h02000800, 1'b0);
        apb(OFS_INT_MASK, 1'b1, 32'h00000FFF);
        stall <= 0;
        repeat (6) @(posedge ref_clk);
        rd(OFS_CHANNEL_STATE, CHANNEL_STATE_RESET, 1'b0);
        irq_is(1'b1);
        rd(OFS_INT_FLAG, 32'h00000208, 1'b0);
        apb(OFS_INT_FLAG, 1'b1, 32'h00000208);
        irq_is(1'b0);
        apb(OFS_INT_MASK, 1'b1, 32'h0);
        pulse(0);
        repeat (6) @(posedge ref_clk);
        irq_is(1'b0);
        rd(OFS_INT_FLAG, 32'h00000001, 1'b0);
        apb(OFS_INT_MASK, 1'b1, 32'h00000001);
        irq_is(1'b1);
        apb(OFS_INT_FLAG, 1'b1, 32'h00000001);
        irq_is(1'b0);
        // Async users 2,14; sync users 3,15; resync users 1,13
        path_chk(16'h4004, 16'h8008, 16'h2002);
        repeat (6) @(posedge ref_clk);
        rd(OFS_INT_FLAG, 32'h0000000E, 1'b0);
        irq_is(1'b0);
        end_sim();
    end
endmodule
